/* File: design/tcr_pkg.sv */
// shared constants, types and helpers for the transceiver config bank
package tcr_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BITRATE = 6'h03;
  localparam logic [5:0] IDX_FLOOR   = 6'h04;
  localparam logic [5:0] IDX_QUEUE   = 6'h05;
  localparam logic [5:0] IDX_REF_A   = 6'h06;
  localparam logic [5:0] IDX_PRE_A   = 6'h07;
  localparam logic [5:0] IDX_SW_A    = 6'h08;
  localparam logic [5:0] IDX_REF_B   = 6'h09;
  localparam logic [5:0] IDX_PRE_B   = 6'h0A;
  localparam logic [5:0] IDX_SW_B    = 6'h0B;
  localparam logic [5:0] IDX_RAMP    = 6'h0C;
  localparam logic [5:0] IDX_SET     = 6'h0D;
  localparam logic [5:0] IDX_STATUS  = 6'h10;
  localparam logic [5:0] IDX_MASK    = 6'h11;

  // values after reset
  localparam logic [6:0] BITRATE_RST = 7'h07;
  localparam logic [7:0] FLOOR_RST   = 8'h0C;
  localparam logic [1:0] QSIZE_RST   = 2'h0;
  localparam logic [5:0] THRESH_RST  = 6'h0F;
  localparam logic [7:0] REF_A_RST   = 8'h77;
  localparam logic [7:0] PRE_A_RST   = 8'h64;
  localparam logic [7:0] SW_A_RST    = 8'h32;
  localparam logic [7:0] REF_B_RST   = 8'h74;
  localparam logic [7:0] PRE_B_RST   = 8'h62;
  localparam logic [7:0] SW_B_RST    = 8'h32;
  localparam logic [7:0] RAMP_RST    = 8'h20;
  localparam logic [6:0] DEPTH_RST   = 7'h10;

  // field positions
  localparam int QSIZE_LSB = 6;
  localparam int RAMP_LSB  = 3;

  // interrupt status bits
  localparam int IRQ_ABOVE = 0;
  localparam int IRQ_FULL  = 1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // read channel states
  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } tcr_rd_e;

  // buffer depth in bytes: 16, 32, 48 or 64
  function automatic logic [6:0] tcr_depth_bytes(input logic [1:0] code);
    tcr_depth_bytes = {1'b0, code, 4'h0} + 7'h10;
  endfunction : tcr_depth_bytes

endpackage : tcr_pkg

/* File: design/tcr_synth_select.sv */
// registered chooser between the two synthesizer counter sets
`timescale 1ns/1ps
module tcr_synth_select
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       choice,
  input  wire logic [7:0] ref_a,
  input  wire logic [7:0] pre_a,
  input  wire logic [7:0] sw_a,
  input  wire logic [7:0] ref_b,
  input  wire logic [7:0] pre_b,
  input  wire logic [7:0] sw_b,
  output logic      [7:0] ref_div,
  output logic      [7:0] prescale,
  output logic      [7:0] swallow
);
  import tcr_pkg::*;

  typedef struct packed
  {
    logic [7:0] ref_div;
    logic [7:0] prescale;
    logic [7:0] swallow;
  } tcr_sel_s;

  tcr_sel_s st;
  tcr_sel_s next_st;

  // zero picks the first set, one the second
  always_comb
  begin
    next_st.ref_div  = choice ? ref_b : ref_a;
    next_st.prescale = choice ? pre_b : pre_a;
    next_st.swallow  = choice ? sw_b  : sw_a;
  end

  // reset lands on the first set's defaults
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st.ref_div  <= REF_A_RST;
      st.prescale <= PRE_A_RST;
      st.swallow  <= SW_A_RST;
    end
    else
      st <= next_st;
  end

  assign ref_div  = st.ref_div;
  assign prescale = st.prescale;
  assign swallow  = st.swallow;
endmodule : tcr_synth_select

/* File: design/tcr_level_watch.sv */
// compares the buffer fill level against threshold and depth
`timescale 1ns/1ps
module tcr_level_watch
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [6:0] level,
  input  wire logic [5:0] threshold,
  input  wire logic [1:0] size_code,
  output logic            above,
  output logic            full
);
  import tcr_pkg::*;

  typedef struct packed
  {
    logic above;
    logic full;
  } tcr_lvl_s;

  tcr_lvl_s st;
  tcr_lvl_s next_st;

  // flag follows the level both ways, no latching here
  always_comb
  begin
    next_st.above = level > {1'b0, threshold};
    next_st.full  = level >= tcr_depth_bytes(size_code);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign above = st.above;
  assign full  = st.full;
endmodule : tcr_level_watch

/* File: design/tcr_config_regs.sv */
// transceiver configuration register bank with an AXI4-Lite slave
`timescale 1ns/1ps
module tcr_config_regs
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [tcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [tcr_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [tcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [tcr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [6:0]                 buffer_level,
  output logic      [6:0]                 bit_rate_code,
  output logic      [7:0]                 onoff_floor_level,
  output logic      [6:0]                 buffer_depth,
  output logic      [5:0]                 buffer_threshold,
  output logic      [7:0]                 ref_divider,
  output logic      [7:0]                 prescale_count,
  output logic      [7:0]                 swallow_count,
  output logic      [1:0]                 amp_ramp_setting,
  output logic                            buffer_above_threshold,
  output logic                            irq
);
  import tcr_pkg::*;

  typedef struct packed
  {
    logic       aw_have;
    logic [5:0] aw_idx;
    logic       w_have;
    logic [7:0] w_data;
    logic       w_strb;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    tcr_rd_e    rd;
    logic       arready;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [6:0] bitrate;
    logic [7:0] floor;
    logic [7:0] qcfg;
    logic [7:0] ref_a;
    logic [7:0] pre_a;
    logic [7:0] sw_a;
    logic [7:0] ref_b;
    logic [7:0] pre_b;
    logic [7:0] sw_b;
    logic [7:0] ramp;
    logic       choice;
    logic [6:0] depth;
    logic [1:0] status;
    logic [1:0] mask;
    logic       above_q;
    logic       full_q;
    logic       irq;
  } tcr_regs_s;

  tcr_regs_s st;
  tcr_regs_s next_st;
  logic      lvl_above;
  logic      lvl_full;

  // byte address to register index; low two bits are don't-care
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[7:2];
  endfunction : reg_index

  // which indices answer OKAY; all others answer DECERR
  function automatic logic idx_mapped(input logic [5:0] idx);
    case (idx)
      IDX_BITRATE, IDX_FLOOR, IDX_QUEUE, IDX_REF_A, IDX_PRE_A, IDX_SW_A,
      IDX_REF_B, IDX_PRE_B, IDX_SW_B, IDX_RAMP, IDX_SET, IDX_STATUS,
      IDX_MASK: idx_mapped = 1'b1;
      default:  idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // fill-level comparison, registered inside
  tcr_level_watch u_level
  (
    .clk       (clk),
    .reset     (reset),
    .level     (buffer_level),
    .threshold (st.qcfg[5:0]),
    .size_code (st.qcfg[7:QSIZE_LSB]),
    .above     (lvl_above),
    .full      (lvl_full)
  );

  // active counter set for the synthesizer
  tcr_synth_select u_synth
  (
    .clk      (clk),
    .reset    (reset),
    .choice   (st.choice),
    .ref_a    (st.ref_a),
    .pre_a    (st.pre_a),
    .sw_a     (st.sw_a),
    .ref_b    (st.ref_b),
    .pre_b    (st.pre_b),
    .sw_b     (st.sw_b),
    .ref_div  (ref_divider),
    .prescale (prescale_count),
    .swallow  (swallow_count)
  );

  // bus channels, register writes, reads and interrupt status
  always_comb
  begin
    logic [1:0] clr;
    logic [1:0] set;
    clr     = 2'h0;
    set     = 2'h0;
    next_st = st;

    // address and data are taken in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_have = 1'b1;
      next_st.aw_idx  = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_strb = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // commit once both halves are here; only byte lane 0 carries data
    if (st.aw_have && st.w_have)
    begin
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = idx_mapped(st.aw_idx) ? RESP_OKAY : RESP_DECERR;
      if (st.w_strb)
      begin
        case (st.aw_idx)
          IDX_BITRATE: next_st.bitrate = st.w_data[6:0];
          IDX_FLOOR:   next_st.floor   = st.w_data;
          IDX_QUEUE:   next_st.qcfg    = st.w_data;
          IDX_REF_A:   next_st.ref_a   = st.w_data;
          IDX_PRE_A:   next_st.pre_a   = st.w_data;
          IDX_SW_A:    next_st.sw_a    = st.w_data;
          IDX_REF_B:   next_st.ref_b   = st.w_data;
          IDX_PRE_B:   next_st.pre_b   = st.w_data;
          IDX_SW_B:    next_st.sw_b    = st.w_data;
          IDX_RAMP:    next_st.ramp    = st.w_data;
          IDX_SET:     next_st.choice  = st.w_data[0];
          IDX_MASK:    next_st.mask    = st.w_data[1:0];
          default:     next_st.choice  = st.choice;
        endcase
      end
    end
    // no new write until the response has gone
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready  = !next_st.w_have && !next_st.bvalid;

    // read side: one beat in flight, data held until rready
    case (st.rd)
      RD_IDLE:
      begin
        if (s_axi_arvalid && st.arready)
        begin
          next_st.rd    = RD_DATA;
          next_st.rresp = idx_mapped(reg_index(s_axi_araddr)) ?
                          RESP_OKAY : RESP_DECERR;
          case (reg_index(s_axi_araddr))
            IDX_BITRATE: next_st.rdata = {1'b0, st.bitrate};
            IDX_FLOOR:   next_st.rdata = st.floor;
            IDX_QUEUE:   next_st.rdata = st.qcfg;
            IDX_REF_A:   next_st.rdata = st.ref_a;
            IDX_PRE_A:   next_st.rdata = st.pre_a;
            IDX_SW_A:    next_st.rdata = st.sw_a;
            IDX_REF_B:   next_st.rdata = st.ref_b;
            IDX_PRE_B:   next_st.rdata = st.pre_b;
            IDX_SW_B:    next_st.rdata = st.sw_b;
            IDX_RAMP:    next_st.rdata = st.ramp;
            IDX_SET:     next_st.rdata = {7'h00, st.choice};
            IDX_STATUS:
            begin
              next_st.rdata = {6'h00, st.status};
              clr           = st.status; // read clears what it saw
            end
            IDX_MASK:    next_st.rdata = {6'h00, st.mask};
            default:     next_st.rdata = 8'h00;
          endcase
        end
      end
      RD_DATA:
      begin
        if (s_axi_rready)
          next_st.rd = RD_IDLE;
      end
      default: next_st.rd = RD_IDLE;
    endcase
    next_st.arready = (next_st.rd == RD_IDLE);

    // depth in bytes tracks the size code
    next_st.depth = tcr_depth_bytes(next_st.qcfg[7:QSIZE_LSB]);

    // rising edges of the level flags; set beats a clearing read
    set[IRQ_ABOVE]  = lvl_above && !st.above_q;
    set[IRQ_FULL]   = lvl_full && !st.full_q;
    next_st.above_q = lvl_above;
    next_st.full_q  = lvl_full;
    next_st.status  = (st.status & ~clr) | set;
    next_st.irq     = |(next_st.status & next_st.mask);
  end

  // reset loads the power-on defaults
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st         <= '0;
      st.rd      <= RD_IDLE;
      st.bitrate <= BITRATE_RST;
      st.floor   <= FLOOR_RST;
      st.qcfg    <= {QSIZE_RST, THRESH_RST};
      st.depth   <= DEPTH_RST;
      st.ref_a   <= REF_A_RST;
      st.pre_a   <= PRE_A_RST;
      st.sw_a    <= SW_A_RST;
      st.ref_b   <= REF_B_RST;
      st.pre_b   <= PRE_B_RST;
      st.sw_b    <= SW_B_RST;
      st.ramp    <= RAMP_RST;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register; the level flag straight from the level watcher's register
  assign s_axi_awready          = st.awready;
  assign s_axi_wready           = st.wready;
  assign s_axi_bvalid           = st.bvalid;
  assign s_axi_bresp            = st.bresp;
  assign s_axi_arready          = st.arready;
  assign s_axi_rvalid           = (st.rd == RD_DATA);
  assign s_axi_rdata            = {24'h000000, st.rdata};
  assign s_axi_rresp            = st.rresp;
  assign bit_rate_code          = st.bitrate;
  assign onoff_floor_level      = st.floor;
  assign buffer_depth           = st.depth;
  assign buffer_threshold       = st.qcfg[5:0];
  assign amp_ramp_setting       = st.ramp[RAMP_LSB+1:RAMP_LSB];
  assign buffer_above_threshold = lvl_above;
  assign irq                    = st.irq;

  default clocking cb @(posedge clk);
  endclocking

  sequence s_both_held;
    st.aw_have && st.w_have;
  endsequence

  sequence s_level_rose;
    !buffer_above_threshold ##1 buffer_above_threshold;
  endsequence

  a_bitrate_reset: assert property (
    reset |=> bit_rate_code == 7'h07)
    else $error("bit rate code wrong after reset");

  a_floor_reset: assert property (
    reset |=> onoff_floor_level == 8'h0C)
    else $error("floor level wrong after reset");

  a_depth_map: assert property (
    disable iff (reset)
    $changed(st.qcfg[7:6]) |-> buffer_depth ==
      (7'h10 + {1'b0, st.qcfg[7:6], 4'h0}))
    else $error("buffer depth does not match size code");

  a_thresh_reset: assert property (
    reset |=> buffer_threshold == 6'h0F && buffer_depth == 7'h10)
    else $error("threshold or depth wrong after reset");

  a_set_choice: assert property (
    disable iff (reset)
    !reset ##1 1 |-> ref_divider ==
      ($past(st.choice) ? $past(st.ref_b) : $past(st.ref_a)))
    else $error("active reference divider from wrong set");

  a_set_a_reset: assert property (
    reset |=> ref_divider == 8'h77 && prescale_count == 8'h64 &&
              swallow_count == 8'h32)
    else $error("first counter set wrong after reset");

  a_set_b_reset: assert property (
    reset |=> st.ref_b == 8'h74 && st.pre_b == 8'h62 && st.sw_b == 8'h32)
    else $error("second counter set wrong after reset");

  a_level_flag: assert property (
    disable iff (reset)
    (buffer_level > {1'b0, buffer_threshold}) |=> buffer_above_threshold)
    else $error("level flag missed a fill above threshold");

  a_level_drop: assert property (
    disable iff (reset)
    (buffer_level <= {1'b0, buffer_threshold}) |=> !buffer_above_threshold)
    else $error("level flag stuck after level fell back");

  a_irq_sticky: assert property (
    disable iff (reset)
    s_level_rose |=> st.status[0] && (!st.mask[0] || irq))
    else $error("level event not recorded in status");

  a_write_answer: assert property (
    disable iff (reset)
    s_both_held |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
    else $error("write response not raised after both halves");

  // read data stands the cycle after the address is taken
  a_read_answer: assert property (
    disable iff (reset)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not raised after address taken");

  // a recorded event survives until some read takes it away
  a_status_kept: assert property (
    disable iff (reset)
    st.status[0] && !(s_axi_arvalid && s_axi_arready) |=> st.status[0])
    else $error("level event lost without a status read");
endmodule : tcr_config_regs

/* File: verif/tcr_config_regs_test.sv */
// self-checking bench for the transceiver config register bank
`timescale 1ns/1ps
module tcr_config_regs_test;
  import tcr_pkg::*;

  typedef struct {
    logic [7:0]  a;
    logic [31:0] rst;
    logic [31:0] wd;
    logic [31:0] rb;
    logic [1:0]  rsp;
  } tcr_row_s;

  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [6:0]        buffer_level;
  logic [6:0]        bit_rate_code;
  logic [7:0]        onoff_floor_level;
  logic [6:0]        buffer_depth;
  logic [5:0]        buffer_threshold;
  logic [7:0]        ref_divider;
  logic [7:0]        prescale_count;
  logic [7:0]        swallow_count;
  logic [1:0]        amp_ramp_setting;
  logic              buffer_above_threshold;
  logic              irq;
  int                n_fail;
  int                checks_done;
  tcr_row_s          rows [12];

  tcr_config_regs u_tcr_config_regs (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .buffer_level, .bit_rate_code,
    .onoff_floor_level, .buffer_depth, .buffer_threshold, .ref_divider,
    .prescale_count, .swallow_count, .amp_ramp_setting,
    .buffer_above_threshold, .irq
  );

  // free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  task automatic chkr(input logic [1:0] g, input logic [1:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected resp at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chkr

  // active counter set packed into one word
  function automatic logic [31:0] active_set;
    active_set = {8'h00, ref_divider, prescale_count, swallow_count};
  endfunction : active_set

  // one write; each half released on its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic da;
    logic dw;
    @(posedge clk);
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw))
    begin
      @(posedge clk);
      if (s_axi_awready && !da)
      begin
        da = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !dw)
      begin
        dw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // let registered outputs land; next driver realigns to an edge
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic lvl(input logic [6:0] v);
    @(posedge clk);
    buffer_level <= v;
    settle();
  endtask : lvl

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // cuts a hang short; the whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    n_fail = 0;
    checks_done = 0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    buffer_level = 7'h00;
    reset = 1'b1;
    // address, value after reset, write data, read-back, response
    rows = '{
      '{8'h0C, 32'h07, 32'hFF, 32'h7F, RESP_OKAY},
      '{8'h10, 32'h0C, 32'h5A, 32'h5A, RESP_OKAY},
      '{8'h14, 32'h0F, 32'hC5, 32'hC5, RESP_OKAY},
      '{8'h18, 32'h77, 32'hA1, 32'hA1, RESP_OKAY},
      '{8'h1C, 32'h64, 32'hA2, 32'hA2, RESP_OKAY},
      '{8'h20, 32'h32, 32'hA3, 32'hA3, RESP_OKAY},
      '{8'h24, 32'h74, 32'hB1, 32'hB1, RESP_OKAY},
      '{8'h28, 32'h62, 32'hB2, 32'hB2, RESP_OKAY},
      '{8'h2C, 32'h32, 32'hB3, 32'hB3, RESP_OKAY},
      '{8'h30, 32'h20, 32'h18, 32'h18, RESP_OKAY},
      '{8'h34, 32'h00, 32'h01, 32'h01, RESP_OKAY},
      '{8'h38, 32'h00, 32'h55, 32'h00, RESP_DECERR}};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset value, write, read-back for every row
    foreach (rows[i])
    begin
      axr(rows[i].a, d, r);
      chk(d, rows[i].rst);
      chkr(r, rows[i].rsp);
      axw(rows[i].a, rows[i].wd, r);
      chkr(r, rows[i].rsp);
      axr(rows[i].a, d, r);
      chk(d, rows[i].rb);
    end
    $display("test table done");
    // set choice is 1 now: second set drives the synthesizer
    settle();
    chk(active_set(), 32'hB1B2B3);
    chk(32'(amp_ramp_setting), 32'h3);
    axw(8'h34, 32'h0, r);
    settle();
    chk(active_set(), 32'hA1A2A3);
    $display("test set choice done");
    // every size code, threshold kept at fifteen
    for (int i = 0; i < 4; i++)
    begin
      axw(8'h14, {24'h0, i[1:0], 6'h0F}, r);
      settle();
      chk(32'(buffer_depth), 32'(16 * (i + 1)));
    end
    $display("test depth done");
    // level flag at the threshold boundary, masked then unmasked
    lvl(7'd15);
    chk(32'(buffer_above_threshold), 32'h0);
    lvl(7'd16);
    chk(32'(buffer_above_threshold), 32'h1);
    chk(32'(irq), 32'h0);
    axr(8'h40, d, r);
    chk(d, 32'h1);
    axr(8'h40, d, r);
    chk(d, 32'h0);
    lvl(7'd15);
    chk(32'(buffer_above_threshold), 32'h0);
    axw(8'h44, 32'h1, r);
    lvl(7'd16);
    chk(32'(irq), 32'h1);
    axr(8'h40, d, r);
    chk(d, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    // full rises while its mask bit is off
    lvl(7'd64);
    chk(32'(irq), 32'h0);
    axr(8'h40, d, r);
    chk(d, 32'h2);
    $display("test level and interrupt done");
    // second reset in mid-run restores defaults at the ports
    lvl(7'd0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(bit_rate_code), 32'h07);
    chk(32'(onoff_floor_level), 32'h0C);
    chk(32'(buffer_depth), 32'h10);
    chk(32'(buffer_threshold), 32'h0F);
    chk(active_set(), 32'h776432);
    chk(32'({amp_ramp_setting, irq}), 32'h0);
    axr(8'h24, d, r);
    chk(d, 32'h74);
    $display("test reset done");
    // a cleared strobe stores nothing; status ignores writes
    s_axi_wstrb <= 4'h0;
    axw(8'h10, 32'hEE, r);
    chkr(r, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axr(8'h10, d, r);
    chk(d, 32'h0C);
    axw(8'h40, 32'h3, r);
    chkr(r, RESP_OKAY);
    axr(8'h40, d, r);
    chk(d, 32'h0);
    $display("test strobe done");
    complete_run();
  end

endmodule : tcr_config_regs_test
